//--- gam_edge_det.sv
`timescale 1ns/10ps
module gam_edge_det #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [W-1:0] pin_in,
  input wire logic [W-1:0] any_edge,
  input wire logic [W-1:0] fall_sel,
  output logic [W-1:0] event_hit
);
  logic [W-1:0] prev;
  logic [W-1:0] rise;
  logic [W-1:0] fall;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prev <= '0;
    end else begin
      prev <= pin_in;
    end
  end

  assign rise = pin_in & ~prev;
  assign fall = ~pin_in & prev;
  // Single selected edge, or both edges
  assign event_hit = (any_edge & (rise | fall)) |
                     (~any_edge & ((fall_sel & fall) | (~fall_sel & rise)));
endmodule

//--- gam_mux.sv
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/10ps
// How it works
// - Port B pin 3 with select bit three clear feeds the external clock input.
// - Port A pins 0 and 1 carry timer 0 input/complement and timer 0 output.
// - Port A pins 6 and 7 carry timer 1 input/complement and timer 1 output.
// - Port A has no select bits; enabling pin 0, 1, 6 or 7 activates its one function, pins 2 to 5 have none.
// - Port C pins 0,1 with select set go analog, comparator input or LED sink.
// - Port C pin 2 with select set goes analog input or LED sink.
// - Port D pin 0 is reset pin when select set, else GPIO output only.
// - Port A pins interrupt on one chosen edge, rising or falling.
// - Port C pins interrupt on every edge.
// - A pin with alternate function disabled is plain GPIO.
// - In alternate function the peripheral, not direction, controls the driver.
// - Timer mode picks between input and complementary output on pins 0 and 6.
module gam_mux
  import gam_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic [7:0] PORT_A_IN,
  input wire logic [7:0] PORT_B_IN,
  input wire logic [7:0] PORT_C_IN,
  input wire logic PORT_D_IN,
  output gam_pkg::gam_port_t PORT_A_DRV,
  output gam_pkg::gam_port_t PORT_B_DRV,
  output gam_pkg::gam_port_t PORT_C_DRV,
  output logic PORT_D_OUT,
  output logic PORT_D_OE,
  input wire logic TIMER0_IN_MODE,
  input wire logic TIMER0_OUTPUT,
  input wire logic TIMER0_OUT_COMPLEMENT,
  input wire logic TIMER1_IN_MODE,
  input wire logic TIMER1_OUTPUT,
  input wire logic TIMER1_OUT_COMPLEMENT,
  input wire logic COMPARATOR_RESULT_OUT,
  input wire logic [7:0] LED_ENABLE,
  input wire logic RESET_DRIVE,
  output logic TIMER0_INPUT,
  output logic TIMER1_INPUT,
  output logic EXTERNAL_CLOCK_INPUT,
  output logic EXTERNAL_CLOCK_ROUTED,
  output logic [5:0] ANALOG_ROUTE_B,
  output logic [2:0] ANALOG_ROUTE_C,
  output logic [1:0] COMPARATOR_IN_ROUTE,
  output logic EXT_RESET_REQ,
  output logic IRQ
);

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [7:0] alt_function_enable_a, alt_function_enable_b, alt_function_enable_c;
  logic alt_function_enable_d;
  logic [7:0] function_select_set_one_b, function_select_set_one_c;
  logic function_select_set_one_d;
  logic [7:0] dir_a, dir_b, dir_c;
  logic [7:0] out_a, out_b, out_c;
  logic out_d;
  logic [7:0] stat_a, stat_c, mask_a, mask_c, edge_fall_a;

  // Port A has no select register, so no address decodes to one
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      alt_function_enable_a <= RST_ZERO;
      alt_function_enable_b <= RST_ZERO;
      alt_function_enable_c <= RST_ZERO;
      alt_function_enable_d <= RST_AF_D;
      function_select_set_one_b <= RST_ZERO;
      function_select_set_one_c <= RST_ZERO;
      function_select_set_one_d <= RST_SEL_D;
      dir_a <= RST_DIR;
      dir_b <= RST_DIR;
      dir_c <= RST_DIR;
      out_a <= RST_ZERO;
      out_b <= RST_ZERO;
      out_c <= RST_ZERO;
      out_d <= 1'b0;
      mask_a <= RST_ZERO;
      mask_c <= RST_ZERO;
      edge_fall_a <= RST_ZERO;
    end else if (WR) begin
      case (ADDR)
        ADDR_AF_A: alt_function_enable_a <= WDATA;
        ADDR_AF_B: alt_function_enable_b <= WDATA;
        ADDR_AF_C: alt_function_enable_c <= WDATA;
        ADDR_AF_D: alt_function_enable_d <= WDATA[0];
        ADDR_SEL_B: function_select_set_one_b <= WDATA;
        ADDR_SEL_C: function_select_set_one_c <= WDATA;
        ADDR_SEL_D: function_select_set_one_d <= WDATA[0];
        ADDR_DIR_A: dir_a <= WDATA;
        ADDR_DIR_B: dir_b <= WDATA;
        ADDR_DIR_C: dir_c <= WDATA;
        ADDR_OUT_A: out_a <= WDATA;
        ADDR_OUT_B: out_b <= WDATA;
        ADDR_OUT_C: out_c <= WDATA;
        ADDR_OUT_D: out_d <= WDATA[0];
        ADDR_MASK_A: mask_a <= WDATA;
        ADDR_MASK_C: mask_c <= WDATA;
        ADDR_EDGE_A: edge_fall_a <= WDATA;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Alternate function routing
  // ----------------------------------------------------------------
  logic [7:0] alt_out_a, alt_oe_a, alt_out_c, alt_oe_c;
  logic reset_mode, clk_mode;
  logic [7:0] led_mode;

  always_comb begin
    alt_out_a = 8'h00;
    alt_oe_a = 8'h00;
    alt_out_a[PA_T0_IO] = TIMER0_OUT_COMPLEMENT;
    alt_oe_a[PA_T0_IO] = ~TIMER0_IN_MODE;
    alt_out_a[PA_T0_OUT] = TIMER0_OUTPUT;
    alt_oe_a[PA_T0_OUT] = 1'b1;
    alt_out_a[PA_T1_IO] = TIMER1_OUT_COMPLEMENT;
    alt_oe_a[PA_T1_IO] = ~TIMER1_IN_MODE;
    alt_out_a[PA_T1_OUT] = TIMER1_OUTPUT;
    alt_oe_a[PA_T1_OUT] = 1'b1;
  end

  // LED sink pulls the pin low; pins 0 to 2 share the pad with analog inputs
  assign led_mode = function_select_set_one_c & LED_ENABLE;

  always_comb begin
    alt_out_c = 8'h00;
    alt_oe_c = led_mode;
    alt_out_c[PC_COMP_OUT] = ~function_select_set_one_c[PC_COMP_OUT] & COMPARATOR_RESULT_OUT;
    alt_oe_c[PC_COMP_OUT] = ~function_select_set_one_c[PC_COMP_OUT] | led_mode[PC_COMP_OUT];
  end

  assign clk_mode = alt_function_enable_b[PB_CLK] & ~function_select_set_one_b[PB_CLK];
  assign reset_mode = alt_function_enable_d & function_select_set_one_d;

  // Reserved choices leave the driver off; port B functions are all inputs
  gam_pin_cell #(.W(8), .RST_OE(8'h00)) u_cell_a (
    .clk(CLK), .reset_n(RESET_N), .af_en(alt_function_enable_a),
    .gpio_out(out_a), .gpio_oe(~dir_a), .alt_out(alt_out_a), .alt_oe(alt_oe_a),
    .pin_out(PORT_A_DRV.out), .pin_oe(PORT_A_DRV.oe)
  );
  gam_pin_cell #(.W(8), .RST_OE(8'h00)) u_cell_b (
    .clk(CLK), .reset_n(RESET_N), .af_en(alt_function_enable_b),
    .gpio_out(out_b), .gpio_oe(~dir_b), .alt_out(8'h00), .alt_oe(8'h00),
    .pin_out(PORT_B_DRV.out), .pin_oe(PORT_B_DRV.oe)
  );
  gam_pin_cell #(.W(8), .RST_OE(8'h00)) u_cell_c (
    .clk(CLK), .reset_n(RESET_N), .af_en(alt_function_enable_c),
    .gpio_out(out_c), .gpio_oe(~dir_c), .alt_out(alt_out_c), .alt_oe(alt_oe_c),
    .pin_out(PORT_C_DRV.out), .pin_oe(PORT_C_DRV.oe)
  );
  // Outside reset mode the pin is an output only, whatever the enable says
  gam_pin_cell #(.W(1), .RST_OE(1'b0)) u_cell_d (
    .clk(CLK), .reset_n(RESET_N), .af_en(reset_mode),
    .gpio_out(out_d), .gpio_oe(1'b1), .alt_out(1'b0), .alt_oe(RESET_DRIVE),
    .pin_out(PORT_D_OUT), .pin_oe(PORT_D_OE)
  );

  // ----------------------------------------------------------------
  // Peripheral side
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      TIMER0_INPUT <= 1'b0;
      TIMER1_INPUT <= 1'b0;
      EXTERNAL_CLOCK_INPUT <= 1'b0;
      EXTERNAL_CLOCK_ROUTED <= 1'b0;
      ANALOG_ROUTE_B <= 6'h00;
      ANALOG_ROUTE_C <= 3'h0;
      COMPARATOR_IN_ROUTE <= 2'h0;
      EXT_RESET_REQ <= 1'b0;
    end else begin
      TIMER0_INPUT <= alt_function_enable_a[PA_T0_IO] & TIMER0_IN_MODE &
                      PORT_A_IN[PA_T0_IO];
      TIMER1_INPUT <= alt_function_enable_a[PA_T1_IO] & TIMER1_IN_MODE &
                      PORT_A_IN[PA_T1_IO];
      EXTERNAL_CLOCK_ROUTED <= clk_mode;
      EXTERNAL_CLOCK_INPUT <= clk_mode & PORT_B_IN[PB_CLK];
      ANALOG_ROUTE_B <= alt_function_enable_b[PB_ANA_LAST:0] &
                        function_select_set_one_b[PB_ANA_LAST:0];
      ANALOG_ROUTE_C <= alt_function_enable_c[PC_ANA_LAST:0] &
                        function_select_set_one_c[PC_ANA_LAST:0] &
                        ~LED_ENABLE[PC_ANA_LAST:0];
      COMPARATOR_IN_ROUTE <= alt_function_enable_c[PC_CMP_LAST:0] &
                             function_select_set_one_c[PC_CMP_LAST:0] &
                             ~LED_ENABLE[PC_CMP_LAST:0];
      // Reset pin is active low; in GPIO mode its level is never read
      EXT_RESET_REQ <= reset_mode & ~PORT_D_IN;
    end
  end

  // ----------------------------------------------------------------
  // Pin interrupts
  // ----------------------------------------------------------------
  logic [7:0] hit_a, hit_c;
  logic rd_stat_a, rd_stat_c;

  gam_edge_det #(.W(8)) u_edge_a (
    .clk(CLK), .reset_n(RESET_N), .pin_in(PORT_A_IN), .any_edge(8'h00),
    .fall_sel(edge_fall_a), .event_hit(hit_a)
  );
  gam_edge_det #(.W(8)) u_edge_c (
    .clk(CLK), .reset_n(RESET_N), .pin_in(PORT_C_IN), .any_edge(8'hff),
    .fall_sel(8'h00), .event_hit(hit_c)
  );

  assign rd_stat_a = RD && (ADDR == ADDR_STAT_A);
  assign rd_stat_c = RD && (ADDR == ADDR_STAT_C);

  // A new event in the clearing read's cycle survives the clear
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      stat_a <= RST_ZERO;
      stat_c <= RST_ZERO;
    end else begin
      stat_a <= (rd_stat_a ? 8'h00 : stat_a) | hit_a;
      stat_c <= (rd_stat_c ? 8'h00 : stat_c) | hit_c;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |((stat_a & mask_a) | (stat_c & mask_c));
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      RDATA <= RST_ZERO;
    end else if (RD) begin
      case (ADDR)
        ADDR_AF_A: RDATA <= alt_function_enable_a;
        ADDR_AF_B: RDATA <= alt_function_enable_b;
        ADDR_AF_C: RDATA <= alt_function_enable_c;
        ADDR_AF_D: RDATA <= {7'h00, alt_function_enable_d};
        ADDR_SEL_B: RDATA <= function_select_set_one_b;
        ADDR_SEL_C: RDATA <= function_select_set_one_c;
        ADDR_SEL_D: RDATA <= {7'h00, function_select_set_one_d};
        ADDR_DIR_A: RDATA <= dir_a;
        ADDR_DIR_B: RDATA <= dir_b;
        ADDR_DIR_C: RDATA <= dir_c;
        ADDR_OUT_A: RDATA <= out_a;
        ADDR_OUT_B: RDATA <= out_b;
        ADDR_OUT_C: RDATA <= out_c;
        ADDR_OUT_D: RDATA <= {7'h00, out_d};
        ADDR_IN_A: RDATA <= PORT_A_IN;
        ADDR_IN_B: RDATA <= PORT_B_IN;
        ADDR_IN_C: RDATA <= PORT_C_IN;
        ADDR_IN_D: RDATA <= {7'h00, reset_mode ? PORT_D_IN : out_d};
        ADDR_STAT_A: RDATA <= stat_a;
        ADDR_STAT_C: RDATA <= stat_c;
        ADDR_MASK_A: RDATA <= mask_a;
        ADDR_MASK_C: RDATA <= mask_c;
        ADDR_EDGE_A: RDATA <= edge_fall_a;
        default: RDATA <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_clk_route;
    @(posedge CLK) disable iff (!RESET_N)
    clk_mode |=> EXTERNAL_CLOCK_INPUT == $past(PORT_B_IN[PB_CLK]);
  endproperty
  a_clk_route: assert property (p_clk_route) else $error("clock pin not routed");

  property p_t0_out;
    @(posedge CLK) disable iff (!RESET_N)
    alt_function_enable_a[PA_T0_OUT] |=>
      PORT_A_DRV.oe[PA_T0_OUT] && PORT_A_DRV.out[PA_T0_OUT] == $past(TIMER0_OUTPUT);
  endproperty
  a_t0_out: assert property (p_t0_out) else $error("timer 0 output pin wrong");

  property p_t1_out;
    @(posedge CLK) disable iff (!RESET_N)
    alt_function_enable_a[PA_T1_OUT] |=>
      PORT_A_DRV.oe[PA_T1_OUT] && PORT_A_DRV.out[PA_T1_OUT] == $past(TIMER1_OUTPUT);
  endproperty
  a_t1_out: assert property (p_t1_out) else $error("timer 1 output pin wrong");

  property p_t0_dir;
    @(posedge CLK) disable iff (!RESET_N)
    alt_function_enable_a[PA_T0_IO] |=> PORT_A_DRV.oe[PA_T0_IO] == !$past(TIMER0_IN_MODE);
  endproperty
  a_t0_dir: assert property (p_t0_dir) else $error("timer 0 pin direction wrong");

  property p_gpio_plain;
    @(posedge CLK) disable iff (!RESET_N)
    !alt_function_enable_b[0] |=> PORT_B_DRV.oe[0] == !$past(dir_b[0]);
  endproperty
  a_gpio_plain: assert property (p_gpio_plain) else $error("plain gpio direction lost");

  property p_pd0_output;
    @(posedge CLK) disable iff (!RESET_N)
    !reset_mode |=> PORT_D_OE && PORT_D_OUT == $past(out_d) && !EXT_RESET_REQ;
  endproperty
  a_pd0_output: assert property (p_pd0_output) else $error("port d gpio not output");

  property p_comp_out;
    @(posedge CLK) disable iff (!RESET_N)
    alt_function_enable_c[PC_COMP_OUT] && !function_select_set_one_c[PC_COMP_OUT] |=>
      PORT_C_DRV.oe[PC_COMP_OUT] && PORT_C_DRV.out[PC_COMP_OUT] == $past(COMPARATOR_RESULT_OUT);
  endproperty
  a_comp_out: assert property (p_comp_out) else $error("comparator output not driven");

  property p_analog_b;
    @(posedge CLK) disable iff (!RESET_N)
    alt_function_enable_b[4] && function_select_set_one_b[4] |=>
      ANALOG_ROUTE_B[4] && !PORT_B_DRV.oe[4];
  endproperty
  a_analog_b: assert property (p_analog_b) else $error("analog channel not routed");

  property p_any_edge;
    @(posedge CLK) disable iff (!RESET_N)
    PORT_C_IN[5] != $past(PORT_C_IN[5]) |=> stat_c[5];
  endproperty
  a_any_edge: assert property (p_any_edge) else $error("port c edge lost");

  property p_one_edge;
    @(posedge CLK) disable iff (!RESET_N)
    $fell(PORT_A_IN[2]) && !edge_fall_a[2] && !rd_stat_a && !stat_a[2] |=> !stat_a[2];
  endproperty
  a_one_edge: assert property (p_one_edge) else $error("wrong edge raised interrupt");

  c_clk_mode: cover property (@(posedge CLK) disable iff (!RESET_N) EXTERNAL_CLOCK_ROUTED);
  c_led_sink: cover property (@(posedge CLK) disable iff (!RESET_N) |led_mode);
  c_irq: cover property (@(posedge CLK) disable iff (!RESET_N) IRQ ##1 rd_stat_a);
  c_reset_pin: cover property (@(posedge CLK) disable iff (!RESET_N) EXT_RESET_REQ);

endmodule

//--- gam_mux_tb.sv
`timescale 1ns/10ps
module gam_mux_tb;
  import gam_pkg::*;
  logic CLK, RESET_N, WR, RD;
  logic [7:0] ADDR, WDATA, RDATA, LED_ENABLE, ext_a, ext_b, ext_c;
  logic T0M, T0O, T0C, T1M, T1O, T1C, CMP, RDRV, ext_d;
  logic T0I, T1I, CKI, CKR, ERQ, IRQ, D_OUT, D_OE;
  logic [5:0] ANB;
  logic [2:0] ANC;
  logic [1:0] CIR;
  wire [7:0] pin_a, pin_b, pin_c;
  wire pin_d;
  gam_port_t DA, DB, DC;
  int err_count, compares;
  logic [7:0] rv;

  gam_mux u_dut (.CLK(CLK), .RESET_N(RESET_N), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .PORT_A_IN(pin_a), .PORT_B_IN(pin_b),
    .PORT_C_IN(pin_c), .PORT_D_IN(pin_d), .PORT_A_DRV(DA), .PORT_B_DRV(DB),
    .PORT_C_DRV(DC), .PORT_D_OUT(D_OUT), .PORT_D_OE(D_OE), .TIMER0_IN_MODE(T0M),
    .TIMER0_OUTPUT(T0O), .TIMER0_OUT_COMPLEMENT(T0C), .TIMER1_IN_MODE(T1M),
    .TIMER1_OUTPUT(T1O), .TIMER1_OUT_COMPLEMENT(T1C), .COMPARATOR_RESULT_OUT(CMP),
    .LED_ENABLE(LED_ENABLE), .RESET_DRIVE(RDRV), .TIMER0_INPUT(T0I),
    .TIMER1_INPUT(T1I), .EXTERNAL_CLOCK_INPUT(CKI), .EXTERNAL_CLOCK_ROUTED(CKR),
    .ANALOG_ROUTE_B(ANB), .ANALOG_ROUTE_C(ANC), .COMPARATOR_IN_ROUTE(CIR),
    .EXT_RESET_REQ(ERQ), .IRQ(IRQ));

  gam_pin_peer u_peer (.drv_a(DA), .drv_b(DB), .drv_c(DC), .d_out(D_OUT),
    .d_oe(D_OE), .ext_a(ext_a), .ext_b(ext_b), .ext_c(ext_c), .ext_d(ext_d),
    .pin_a(pin_a), .pin_b(pin_b), .pin_c(pin_c), .pin_d(pin_d));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask

  // Data load on the edge that samples the strobe and hold until the next read; sample just after that edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 d = RDATA;
  endtask

  task automatic settle();
    repeat (3) @(posedge CLK);
    #1;
  endtask

  task automatic report_and_stop();
    if (err_count == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_pin();
    rd(ADDR_AF_D, rv); chk("af_d", rv, 8'h01);
    rd(ADDR_SEL_D, rv); chk("sel_d", rv, 8'h01);
    rd(ADDR_DIR_A, rv); chk("dir_a", rv, 8'hff);
    rd(8'h07, rv); chk("unmapped", rv, 8'h00);
    @(posedge CLK); RDRV <= 1'b1;
    settle(); chk("d_drive", {D_OE, D_OUT}, 2'b10);
    @(posedge CLK); RDRV <= 1'b0; ext_d <= 1'b0;
    settle(); chk("d_req", ERQ, 1'b1);
    @(posedge CLK); ext_d <= 1'b1;
    settle(); chk("d_noreq", ERQ, 1'b0);
    wr(ADDR_SEL_D, 8'h00); wr(ADDR_OUT_D, 8'h00);
    @(posedge CLK); ext_d <= 1'b0;
    settle(); chk("d_gpio", {D_OE, D_OUT, ERQ}, 3'b100);
    wr(ADDR_OUT_D, 8'h01); rd(ADDR_IN_D, rv);
    chk("in_d", {rv, D_OUT}, 9'h003);
  endtask

  task automatic t_port_a();
    wr(ADDR_DIR_A, 8'h00); wr(ADDR_OUT_A, 8'ha5);
    settle(); chk("a_gpio", {DA.oe, DA.out}, 16'hffa5);
    @(posedge CLK); {T0M, T0O, T0C, T1M, T1O, T1C} <= 6'b010100; ext_a <= 8'h41;
    wr(ADDR_AF_A, 8'hc3);
    settle(); chk("a_alt", {DA.oe, DA.out & DA.oe}, 16'hbf26);
    chk("a_tin", {T0I, T1I}, 2'b01);
    @(posedge CLK); T0M <= 1'b1;
    settle(); chk("a_t0in", {DA.oe, 7'h0, T0I}, 16'hbe01);
  endtask

  // Bit 3 clear is the clock path; pins 0 to 5 select analog when set
  task automatic t_port_b();
    @(posedge CLK); ext_b <= 8'h08;
    wr(ADDR_AF_B, 8'h3f); wr(ADDR_SEL_B, 8'h37);
    settle(); chk("b_clk", {DB.oe, 6'h0, CKR, CKI}, 16'h0003);
    chk("b_ana", ANB, 6'h37);
    @(posedge CLK); ext_b <= 8'h00;
    settle(); chk("b_clk0", CKI, 1'b0);
    wr(ADDR_SEL_B, 8'h3f);
    settle(); chk("b_sel", {CKR, 2'b0, ANB}, 9'h03f);
  endtask

  task automatic t_port_c();
    @(posedge CLK); LED_ENABLE <= 8'hf0; CMP <= 1'b1;
    wr(ADDR_AF_C, 8'hff); wr(ADDR_SEL_C, 8'h77);
    settle(); chk("c_led", {DC.oe, DC.out & DC.oe}, 16'h7808);
    chk("c_ana", {ANC, CIR}, 5'h1f);
    @(posedge CLK); CMP <= 1'b0; LED_ENABLE <= 8'h01;
    settle(); chk("c_mix", {DC.oe, DC.out & DC.oe}, 16'h0900);
    chk("c_ana2", {ANC, CIR}, 5'h1a);
    wr(ADDR_AF_C, 8'h00);
  endtask

  // Each edge is judged by the IRQ level and then by the status read, which also clears it
  task automatic edge_a(input logic [7:0] v, input logic [7:0] exp, input logic ei);
    @(posedge CLK); ext_a <= v;
    settle(); chk("irq_a", IRQ, ei);
    rd(ADDR_STAT_A, rv); chk("stat_a", rv, exp);
  endtask

  task automatic t_irq();
    wr(ADDR_AF_A, 8'h00); wr(ADDR_DIR_A, 8'hff);
    wr(ADDR_MASK_A, 8'h01); wr(ADDR_MASK_C, 8'h20);
    settle(); rd(ADDR_STAT_A, rv); rd(ADDR_STAT_C, rv);
    edge_a(8'h45, 8'h04, 1'b0);
    edge_a(8'h40, 8'h00, 1'b0);
    edge_a(8'h41, 8'h01, 1'b1);
    settle(); chk("irq_clr", IRQ, 1'b0);
    wr(ADDR_EDGE_A, 8'h01);
    edge_a(8'h40, 8'h01, 1'b1);
    edge_a(8'h41, 8'h00, 1'b0);
    @(posedge CLK); ext_c <= 8'h20;
    settle(); chk("irq_c", IRQ, 1'b1);
    rd(ADDR_STAT_C, rv); chk("stat_c", rv, 8'h20);
    @(posedge CLK); ext_c <= 8'h30;
    settle(); chk("irq_cm", IRQ, 1'b0);
    rd(ADDR_STAT_C, rv); chk("stat_c2", rv, 8'h10);
    @(posedge CLK); ext_c <= 8'h00;
    settle(); chk("irq_cf", IRQ, 1'b1);
    rd(ADDR_STAT_C, rv); chk("stat_c3", rv, 8'h30);
    settle(); chk("irq_mask", IRQ, 1'b0);
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    err_count = 0;
    compares = 0;
    RESET_N = 1'b0; ADDR = 8'h00; WDATA = 8'h00; WR = 1'b0; RD = 1'b0;
    LED_ENABLE = 8'h00; ext_a = 8'h00; ext_b = 8'h00; ext_c = 8'h00; ext_d = 1'b1;
    {T0M, T0O, T0C, T1M, T1O, T1C, CMP, RDRV} = 8'h00;
    repeat (10) @(posedge CLK);
    RESET_N <= 1'b1;
    t_reset_pin();
    t_port_a();
    t_port_b();
    t_port_c();
    t_irq();
    report_and_stop();
  end

  // A hang counts as a mismatch and ends the run through the same report
  initial begin
    repeat (20000) @(posedge CLK);
    err_count++;
    report_and_stop();
  end
endmodule

//--- gam_pin_cell.sv
`timescale 1ns/10ps
module gam_pin_cell #(
  parameter int W = 8,
  parameter logic [W-1:0] RST_OE = '0
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [W-1:0] af_en,
  input wire logic [W-1:0] gpio_out,
  input wire logic [W-1:0] gpio_oe,
  input wire logic [W-1:0] alt_out,
  input wire logic [W-1:0] alt_oe,
  output logic [W-1:0] pin_out,
  output logic [W-1:0] pin_oe
);
  // Alternate function owns both level and direction of the pin
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_out <= '0;
      pin_oe <= RST_OE;
    end else begin
      pin_out <= (af_en & alt_out) | (~af_en & gpio_out);
      pin_oe <= (af_en & alt_oe) | (~af_en & gpio_oe);
    end
  end
endmodule

//--- gam_pin_peer.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Far side of the pins: driven level wins, else the outside level
// ----------------------------------------------------------------
module gam_pin_peer
  import gam_pkg::*;
(
  input gam_pkg::gam_port_t drv_a,
  input gam_pkg::gam_port_t drv_b,
  input gam_pkg::gam_port_t drv_c,
  input wire logic d_out,
  input wire logic d_oe,
  input wire logic [7:0] ext_a,
  input wire logic [7:0] ext_b,
  input wire logic [7:0] ext_c,
  input wire logic ext_d,
  output logic [7:0] pin_a,
  output logic [7:0] pin_b,
  output logic [7:0] pin_c,
  output logic pin_d
);
  // Per-pin resolve; no contention model, a driven level wins where the bench also sets an outside level
  assign pin_a = (drv_a.oe & drv_a.out) | (~drv_a.oe & ext_a);
  assign pin_b = (drv_b.oe & drv_b.out) | (~drv_b.oe & ext_b);
  assign pin_c = (drv_c.oe & drv_c.out) | (~drv_c.oe & ext_c);
  assign pin_d = d_oe ? d_out : ext_d;
endmodule

//--- gam_pkg.sv
package gam_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_AF_A = 8'h00;
  localparam logic [7:0] ADDR_AF_B = 8'h01;
  localparam logic [7:0] ADDR_AF_C = 8'h02;
  localparam logic [7:0] ADDR_AF_D = 8'h03;
  localparam logic [7:0] ADDR_SEL_B = 8'h04;
  localparam logic [7:0] ADDR_SEL_C = 8'h05;
  localparam logic [7:0] ADDR_SEL_D = 8'h06;
  localparam logic [7:0] ADDR_DIR_A = 8'h08;
  localparam logic [7:0] ADDR_DIR_B = 8'h09;
  localparam logic [7:0] ADDR_DIR_C = 8'h0a;
  localparam logic [7:0] ADDR_OUT_A = 8'h0c;
  localparam logic [7:0] ADDR_OUT_B = 8'h0d;
  localparam logic [7:0] ADDR_OUT_C = 8'h0e;
  localparam logic [7:0] ADDR_OUT_D = 8'h0f;
  localparam logic [7:0] ADDR_IN_A = 8'h10;
  localparam logic [7:0] ADDR_IN_B = 8'h11;
  localparam logic [7:0] ADDR_IN_C = 8'h12;
  localparam logic [7:0] ADDR_IN_D = 8'h13;
  localparam logic [7:0] ADDR_STAT_A = 8'h14;
  localparam logic [7:0] ADDR_STAT_C = 8'h15;
  localparam logic [7:0] ADDR_MASK_A = 8'h16;
  localparam logic [7:0] ADDR_MASK_C = 8'h17;
  localparam logic [7:0] ADDR_EDGE_A = 8'h18;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_DIR = 8'hff;
  localparam logic RST_AF_D = 1'b1;
  localparam logic RST_SEL_D = 1'b1;

  // ----------------------------------------------------------------
  // Pin positions
  // ----------------------------------------------------------------
  localparam int PA_T0_IO = 0;
  localparam int PA_T0_OUT = 1;
  localparam int PA_T1_IO = 6;
  localparam int PA_T1_OUT = 7;
  localparam int PB_CLK = 3;
  localparam int PB_ANA_LAST = 5;
  localparam int PC_ANA_LAST = 2;
  localparam int PC_CMP_LAST = 1;
  localparam int PC_COMP_OUT = 3;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } gam_port_t;

endpackage
